// ===== rtc_regs.vh
// Register map, field positions and constants of the real-time clock register core
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// ========================================================================
// Register offsets
`define RTC_REG_CTRL1      5'h00
`define RTC_REG_CTRL2      5'h01
`define RTC_REG_OFFSET     5'h02
`define RTC_REG_RAM        5'h03
`define RTC_REG_SEC        5'h04
`define RTC_REG_MIN        5'h05
`define RTC_REG_HOUR       5'h06
`define RTC_REG_DAY        5'h07
`define RTC_REG_WDAY       5'h08
`define RTC_REG_MON        5'h09
`define RTC_REG_YEAR       5'h0A
`define RTC_REG_TMR_VAL    5'h10
`define RTC_REG_TMR_CFG    5'h11
`define RTC_REG_LAST       5'h11
`define RTC_REG_FIRST      5'h00
`define RTC_REG_COUNT      18
`define RTC_RST_VAL        8'h00

// ========================================================================
// Control fields
`define RTC_HALT_BIT       5
`define RTC_SRST_BIT       4
`define RTC_SRST_PATTERN   8'h58
`define RTC_COF_MSB        2
`define RTC_COF_LSB        0
`define RTC_OFFS_MSB       6

// ========================================================================
// Serial bus
`define RTC_DEV_ADDR       7'h2A
`define RTC_BIT_LAST       3'h7
`define RTC_BIT_ZERO       3'h0

// ========================================================================
// Timebase and clock output select codes
`define RTC_DIV_W          15
`define RTC_DIV_TOP        15'h7FFF
`define RTC_COF_32K        3'h0
`define RTC_COF_16K        3'h1
`define RTC_COF_8K         3'h2
`define RTC_COF_4K         3'h3
`define RTC_COF_2K         3'h4
`define RTC_COF_1K         3'h5
`define RTC_COF_1HZ        3'h6

// ========================================================================
// BCD limits
`define RTC_BCD_59         8'h59
`define RTC_BCD_23         8'h23
`define RTC_BCD_12         8'h12
`define RTC_BCD_99         8'h99
`define RTC_BCD_ONE        8'h01
`define RTC_WDAY_LAST      8'h06
`define RTC_SEC_MASK       8'h7F

`endif

// ===== rtc_core.v
// Real-time clock register core: serial bus slave, register map, calendar and clock output
// ========================================================================
// Summary of operation
// - Pointer advances after every data byte
// - Pointer wraps from last register to zero
// - Exactly eighteen byte registers exist
// - Every register addressed as a full byte
// - Locations zero and one are control/status
// - Offset register at two trims clock rate
// - Spare RAM byte at location three
// - Locations four to ten are time counters
// - Locations eleven to fifteen hold alarms
// - Last two locations hold countdown timer
// - Time and alarm values are packed BCD
// - Time counters frozen during bus access
// - Clock output only while gate pin high
// - Timebase divided from 32.768 kHz oscillator
// - Clock output selects one of seven rates
// - Master keeps bus at most 400 kbit/s; the bench master uses HALF 8, a 16-cycle bit, 3.125 Mbit/s on its 50 MHz clock
// - Pattern 58h to control resets; bit reads zero
// - Halt bit stops clock, clears divider
`include "rtc_regs.vh"

module rtc_core (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        rst_i,
    // Serial bus pins
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_n_o,
    // Oscillator and clock output
    input  wire        osc_i,
    input  wire        clock_output_gate_pin_i,
    output wire        clock_output_pin_o
);

    // ====================================================================
    // Slave states
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WDAT = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RDAT = 3'h5;
    localparam ST_RACK = 3'h6;

    reg  [7:0]              mem_ff [0:`RTC_REG_COUNT-1];
    reg  [2:0]              st_ff;
    reg  [2:0]              bit_ff;
    reg  [7:0]              shr_ff;
    reg  [7:0]              tx_ff;
    reg  [4:0]              ptr_ff;
    reg                     first_ff;
    reg                     rw_ff;
    reg                     ack_on_ff;
    reg                     busy_ff;
    reg                     scl_q_ff;
    reg                     sda_q_ff;
    reg                     sda_ff;
    reg                     sda_oe_n_ff;
    reg                     osc_q_ff;
    reg  [`RTC_DIV_W-1:0]   div_ff;
    reg                     sec_tick_ff;
    reg                     pend_ff;
    reg                     clock_output_pin_ff;
    reg                     sel_clk;
    integer                 i;

    wire       scl_rise = scl_i & ~scl_q_ff;
    wire       scl_fall = ~scl_i & scl_q_ff;
    wire       start_ev = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
    wire       stop_ev  = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
    wire [7:0] byte_in  = {shr_ff[6:0], sda_i};
    wire       halt     = mem_ff[`RTC_REG_CTRL1][`RTC_HALT_BIT];
    wire       osc_rise = osc_i & ~osc_q_ff;
    wire       tick_go  = ~busy_ff & (pend_ff | sec_tick_ff);
    wire [2:0] cof      = mem_ff[`RTC_REG_CTRL2][`RTC_COF_MSB:`RTC_COF_LSB];
    wire [4:0] ptr_nxt  = (ptr_ff == `RTC_REG_LAST) ? `RTC_REG_FIRST : ptr_ff + 5'h01;
    wire [7:0] rd_val   = (ptr_ff == `RTC_REG_CTRL1) ?
                          (mem_ff[ptr_ff] & ~(8'h01 << `RTC_SRST_BIT)) : mem_ff[ptr_ff];

    assign sda_o              = sda_ff;
    assign sda_oe_n_o         = sda_oe_n_ff;
    assign clock_output_pin_o = clock_output_pin_ff;

    // ====================================================================
    // BCD helpers
    function [7:0] bcd_nxt;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9) begin
                bcd_nxt = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_nxt = {v[7:4], v[3:0] + 4'h1};
            end
        end
    endfunction

    // Last day of month; leap test on BCD year, every fourth year
    function [7:0] mon_last;
        input [7:0] mon;
        input [7:0] yr;
        reg         leap;
        begin
            leap = (~yr[4] & (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) |
                   (yr[4] & (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
            case (mon)
                8'h02: mon_last = leap ? 8'h29 : 8'h28;
                8'h04, 8'h06, 8'h09, 8'h11: mon_last = 8'h30;
                default: mon_last = 8'h31;
            endcase
        end
    endfunction

    // ====================================================================
    // Pin history for edge and start/stop detection
    always @(posedge mclk_i) begin
        if (rst_i) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            osc_q_ff <= 1'b0;
        end else begin
            scl_q_ff <= scl_i;
            sda_q_ff <= sda_i;
            osc_q_ff <= osc_i;
        end
    end

    // ====================================================================
    // Timebase divider; a seconds tick marks each full wrap
    // Offset is loaded at each minute wrap that has no oscillator rise in the same cycle, so a positive value shortens the minute
    always @(posedge mclk_i) begin
        if (rst_i) begin
            div_ff      <= {`RTC_DIV_W{1'b0}};
            sec_tick_ff <= 1'b0;
        end else if (halt) begin
            div_ff      <= {`RTC_DIV_W{1'b0}};
            sec_tick_ff <= 1'b0;
        end else if (tick_go && mem_ff[`RTC_REG_SEC][6:0] == `RTC_BCD_59 && !osc_rise) begin
            div_ff      <= {{(`RTC_DIV_W-7){mem_ff[`RTC_REG_OFFSET][`RTC_OFFS_MSB]}},
                            mem_ff[`RTC_REG_OFFSET][6:0]};
            sec_tick_ff <= 1'b0;
        end else begin
            sec_tick_ff <= osc_rise && (div_ff == `RTC_DIV_TOP);
            if (osc_rise) begin
                div_ff <= div_ff + 15'h0001;
            end
        end
    end

    // ====================================================================
    // Second held while frozen; the release wins over a set
    always @(posedge mclk_i) begin
        if (rst_i) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= busy_ff & (pend_ff | sec_tick_ff);
        end
    end

    // ====================================================================
    // Clock output rate select and gate
    always @* begin
        case (cof)
            `RTC_COF_32K: sel_clk = osc_q_ff;
            `RTC_COF_16K: sel_clk = div_ff[0];
            `RTC_COF_8K:  sel_clk = div_ff[1];
            `RTC_COF_4K:  sel_clk = div_ff[2];
            `RTC_COF_2K:  sel_clk = div_ff[3];
            `RTC_COF_1K:  sel_clk = div_ff[4];
            `RTC_COF_1HZ: sel_clk = div_ff[`RTC_DIV_W-1];
            default:      sel_clk = 1'b0;
        endcase
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            clock_output_pin_ff <= 1'b0;
        end else begin
            clock_output_pin_ff <= clock_output_gate_pin_i & sel_clk;
        end
    end

    // ====================================================================
    // Serial slave, register file and calendar counters
    // Bus writes and counting never meet: counting waits while busy
    always @(posedge mclk_i) begin
        if (rst_i) begin
            st_ff       <= ST_IDLE;
            bit_ff      <= `RTC_BIT_ZERO;
            shr_ff      <= 8'h00;
            tx_ff       <= 8'h00;
            ptr_ff      <= `RTC_REG_FIRST;
            first_ff    <= 1'b0;
            rw_ff       <= 1'b0;
            ack_on_ff   <= 1'b0;
            busy_ff     <= 1'b0;
            sda_ff      <= 1'b1;
            sda_oe_n_ff <= 1'b1;
            for (i = 0; i < `RTC_REG_COUNT; i = i + 1) begin
                mem_ff[i] <= `RTC_RST_VAL;
            end
        end else if (start_ev) begin
            st_ff       <= ST_ADDR;
            bit_ff      <= `RTC_BIT_ZERO;
            first_ff    <= 1'b1;
            busy_ff     <= 1'b1;
            sda_oe_n_ff <= 1'b1;
        end else if (stop_ev) begin
            st_ff       <= ST_IDLE;
            busy_ff     <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end else if (scl_rise) begin
            case (st_ff)
                ST_ADDR, ST_WDAT: begin
                    shr_ff <= byte_in;
                    bit_ff <= bit_ff + 3'h1;
                    if (bit_ff == `RTC_BIT_LAST) begin
                        if (st_ff == ST_ADDR) begin
                            rw_ff <= byte_in[0];
                            st_ff <= (byte_in[7:1] == `RTC_DEV_ADDR) ? ST_AACK : ST_IDLE;
                            busy_ff <= (byte_in[7:1] == `RTC_DEV_ADDR);
                        end else if (first_ff) begin
                            first_ff <= 1'b0;
                            ptr_ff   <= (byte_in[4:0] > `RTC_REG_LAST || byte_in[7:5] != 3'h0) ?
                                        `RTC_REG_FIRST : byte_in[4:0];
                            st_ff    <= ST_WACK;
                        end else begin
                            st_ff  <= ST_WACK;
                            ptr_ff <= ptr_nxt;
                            if (ptr_ff == `RTC_REG_CTRL1 && byte_in == `RTC_SRST_PATTERN) begin
                                for (i = 0; i < `RTC_REG_COUNT; i = i + 1) begin
                                    mem_ff[i] <= `RTC_RST_VAL;
                                end
                            end else if (ptr_ff == `RTC_REG_CTRL1) begin
                                mem_ff[ptr_ff] <= byte_in & ~(8'h01 << `RTC_SRST_BIT);
                            end else begin
                                mem_ff[ptr_ff] <= byte_in;
                            end
                        end
                    end
                end
                ST_RDAT: begin
                    tx_ff  <= {tx_ff[6:0], 1'b0};
                    bit_ff <= bit_ff + 3'h1;
                    if (bit_ff == `RTC_BIT_LAST) begin
                        st_ff  <= ST_RACK;
                        ptr_ff <= ptr_nxt;
                    end
                end
                ST_RACK: begin
                    bit_ff <= `RTC_BIT_ZERO;
                    tx_ff  <= rd_val;
                    st_ff  <= sda_i ? ST_IDLE : ST_RDAT;
                end
                default: begin
                    st_ff <= st_ff;
                end
            endcase
        end else if (scl_fall) begin
            case (st_ff)
                ST_AACK, ST_WACK: begin
                    if (!ack_on_ff) begin
                        ack_on_ff   <= 1'b1;
                        sda_ff      <= 1'b0;
                        sda_oe_n_ff <= 1'b0;
                    end else begin
                        ack_on_ff <= 1'b0;
                        bit_ff    <= `RTC_BIT_ZERO;
                        if (rw_ff && st_ff == ST_AACK) begin
                            st_ff       <= ST_RDAT;
                            tx_ff       <= rd_val;
                            sda_ff      <= rd_val[7];
                            sda_oe_n_ff <= 1'b0;
                        end else begin
                            st_ff       <= ST_WDAT;
                            sda_oe_n_ff <= 1'b1;
                        end
                    end
                end
                ST_RDAT: begin
                    sda_ff      <= tx_ff[7];
                    sda_oe_n_ff <= 1'b0;
                end
                default: begin
                    sda_oe_n_ff <= 1'b1;
                end
            endcase
        end
        // Cascaded BCD counting, seconds up to years. It sits beside the bus branches so that an idle-time
        // tick meeting an scl edge is not dropped. Bus writes need busy and counting needs idle.
        if (!rst_i && tick_go) begin
            if (mem_ff[`RTC_REG_SEC][6:0] != `RTC_BCD_59) begin
                mem_ff[`RTC_REG_SEC] <= bcd_nxt(mem_ff[`RTC_REG_SEC] & `RTC_SEC_MASK);
            end else begin
                mem_ff[`RTC_REG_SEC] <= 8'h00;
                if (mem_ff[`RTC_REG_MIN] != `RTC_BCD_59) begin
                    mem_ff[`RTC_REG_MIN] <= bcd_nxt(mem_ff[`RTC_REG_MIN]);
                end else begin
                    mem_ff[`RTC_REG_MIN] <= 8'h00;
                    if (mem_ff[`RTC_REG_HOUR] != `RTC_BCD_23) begin
                        mem_ff[`RTC_REG_HOUR] <= bcd_nxt(mem_ff[`RTC_REG_HOUR]);
                    end else begin
                        mem_ff[`RTC_REG_HOUR] <= 8'h00;
                        mem_ff[`RTC_REG_WDAY] <= (mem_ff[`RTC_REG_WDAY] == `RTC_WDAY_LAST) ? 8'h00 :
                                                 mem_ff[`RTC_REG_WDAY] + 8'h01;
                        if (mem_ff[`RTC_REG_DAY] != mon_last(mem_ff[`RTC_REG_MON], mem_ff[`RTC_REG_YEAR])) begin
                            mem_ff[`RTC_REG_DAY] <= bcd_nxt(mem_ff[`RTC_REG_DAY]);
                        end else begin
                            mem_ff[`RTC_REG_DAY] <= `RTC_BCD_ONE;
                            if (mem_ff[`RTC_REG_MON] != `RTC_BCD_12) begin
                                mem_ff[`RTC_REG_MON] <= bcd_nxt(mem_ff[`RTC_REG_MON]);
                            end else begin
                                mem_ff[`RTC_REG_MON]  <= `RTC_BCD_ONE;
                                mem_ff[`RTC_REG_YEAR] <= (mem_ff[`RTC_REG_YEAR] == `RTC_BCD_99) ? 8'h00 :
                                                         bcd_nxt(mem_ff[`RTC_REG_YEAR]);
                            end
                        end
                    end
                end
            end
        end
    end

endmodule // rtc_core

// ===== rtc_core_checker.sv
// Port checker for the clock core: bus pin discipline and clock output gating
module rtc_core_checker (
    // Clock and reset
    input wire mclk_i,
    input wire rst_i,
    // Serial bus pins
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    // Clock output
    input wire clock_output_gate_pin_i,
    input wire clock_output_pin_o
);
    // ====================================================================
    // Bus conditions as seen on the system clock
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_start;
        scl_i && $past(scl_i) && !sda_i && $past(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $past(scl_i) && sda_i && !$past(sda_i);
    endsequence
    // ====================================================================
    // Properties
    property p_rst_idle;
        $fell(rst_i) |-> sda_oe_n_o && sda_o && !clock_output_pin_o;
    endproperty
    property p_gate_low;
        !clock_output_gate_pin_i |=> !clock_output_pin_o;
    endproperty
    property p_gate_past;
        clock_output_pin_o |-> $past(clock_output_gate_pin_i);
    endproperty
    // The slave may only move its enable while the serial clock is low
    property p_oe_low;
        $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i);
    endproperty
    property p_hold_high;
        scl_i && $past(scl_i) |-> $stable(sda_oe_n_o) && (sda_oe_n_o || $stable(sda_o));
    endproperty
    property p_ack_hold;
        $fell(sda_oe_n_o) |-> (!sda_oe_n_o) [*8];
    endproperty
    property p_stop_idle;
        s_stop |=> sda_oe_n_o [*3];
    endproperty
    property p_start_listen;
        s_start |=> sda_oe_n_o [*8];
    endproperty
    // ====================================================================
    // Assertions
    a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
    a_gate_low: assert property (p_gate_low) else $error("clock output high with gate low");
    a_gate_past: assert property (p_gate_past) else $error("clock output without gate");
    a_oe_low: assert property (p_oe_low) else $error("data enable moved with clock high");
    a_hold_high: assert property (p_hold_high) else $error("data changed with clock high");
    a_ack_hold: assert property (p_ack_hold) else $error("slave drive too short");
    a_stop_idle: assert property (p_stop_idle) else $error("slave drives after stop");
    a_start_listen: assert property (p_start_listen) else $error("slave drives during address");
endmodule // rtc_core_checker

bind rtc_core rtc_core_checker u_chk (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .clock_output_gate_pin_i(clock_output_gate_pin_i),
    .clock_output_pin_o(clock_output_pin_o)
);

// ===== rtc_i2c_mst.sv
// Behavioural two-wire bus master that talks to the clock core
module rtc_i2c_mst #(
    parameter HALF = 63
) (
    // Clock and resolved data line
    input  wire mclk_i,
    input  wire sda_i,
    // Master drive, 1 releases the line
    output reg  scl_o,
    output reg  sda_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================================================
    // Bus idles released until the first frame
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Half bit time; 63 cycles keeps the 400 kbit/s ceiling, a bench may trade it for run time
    task hw;
        repeat (HALF) @(negedge mclk_i);
    endtask
    // START, also serving as repeated START
    task start;
        sda_o = 1'b1;
        hw;
        scl_o = 1'b1;
        hw;
        sda_o = 1'b0;
        hw;
        scl_o = 1'b0;
        hw;
    endtask
    // STOP from a low clock
    task stop;
        sda_o = 1'b0;
        hw;
        scl_o = 1'b1;
        hw;
        sda_o = 1'b1;
        hw;
    endtask
    // Nine bits MSB first: eight data then acknowledge; sampled just before the fall
    task xfer(input [8:0] d, output [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_o = d[i];
            hw;
            scl_o = 1'b1;
            hw;
            q[i] = sda_i;
            scl_o = 1'b0;
        end
    endtask
endmodule // rtc_i2c_mst

// ===== rtc_core_test.sv
// Self-checking bench for the clock register core
`include "rtc_regs.vh"
module rtc_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       osc_i = 1'b0;
    logic       gate = 1'b1;
    logic       run = 1'b0;
    wire        scl;
    wire        m_sda;
    wire        s_sda;
    wire        s_oe_n;
    wire        clk_out;
    // Pulled-up line: wire-AND of both drivers
    wire        sda = m_sda & (s_oe_n | s_sda);
    int         n_errors = 0;
    int         cmp_count = 0;
    int         edges;
    int         exp_n;
    logic [7:0] wb [0:3];
    logic [7:0] rb [0:18];
    logic [8:0] q;
    logic [7:0] sec = {3'h0, `RTC_REG_SEC};
    // Rows: pointer, value written, value read back
    logic [23:0] rows [0:7] = '{24'h03A5A5, 24'h025555, 24'h103C3C, 24'h11C3C3,
                                24'h0B5959, 24'h0C4242, 24'h003020, 24'h000000};
    rtc_core DUT (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(s_sda),
        .sda_oe_n_o(s_oe_n), .osc_i(osc_i), .clock_output_gate_pin_i(gate), .clock_output_pin_o(clk_out));
    // Short half bit keeps the one-second wait inside the run budget
    rtc_i2c_mst #(.HALF(8)) u_mst (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
    // ====================================================================
    // Clocks and counters
    initial forever #10 mclk_i = ~mclk_i;
    always @(negedge mclk_i) if (run) osc_i <= ~osc_i;
    always @(posedge clk_out) edges++;
    initial begin
        repeat (100000) @(negedge mclk_i);
        n_errors++;
        summarize;
    end
    // ====================================================================
    // Helpers
    task chk(input string nm, input [7:0] got, input [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task sb(input [7:0] d);
        u_mst.xfer({d, 1'b1}, q);
        chk("ack", {7'h0, q[0]}, 8'h00);
    endtask
    task wr(input [7:0] p, input int n);
        u_mst.start;
        sb({`RTC_DEV_ADDR, 1'b0});
        sb(p);
        for (int k = 0; k < n; k++) sb(wb[k]);
        u_mst.stop;
    endtask
    // Pointer set, repeated START, then n bytes with NACK on the last
    task rd(input [7:0] p, input int n);
        u_mst.start;
        sb({`RTC_DEV_ADDR, 1'b0});
        sb(p);
        u_mst.start;
        sb({`RTC_DEV_ADDR, 1'b1});
        for (int k = 0; k < n; k++) begin
            u_mst.xfer({8'hFF, k == n - 1}, q);
            rb[k] = q[8:1];
        end
        u_mst.stop;
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ====================================================================
    // Main sequence
    initial begin
        repeat (10) @(negedge mclk_i);
        rst_i = 1'b0;
        @(negedge mclk_i);
        rd(8'h00, 19);
        foreach (rb[i]) chk("reset", rb[i], 8'h00);
        foreach (rows[i]) begin
            wb[0] = rows[i][15:8];
            wr(rows[i][23:16], 1);
            rd(rows[i][23:16], 1);
            chk("reg", rb[0], rows[i][7:0]);
        end
        // Write across the top of the map, then an out-of-range pointer
        wb[0] = 8'hE7;
        wb[1] = 8'h02;
        wb[2] = 8'h07;
        wr(8'h11, 3);
        rd(8'h1F, 1);
        chk("ptr_range", rb[0], 8'h02);
        rd(8'h11, 3);
        chk("wrap0", rb[0], 8'hE7);
        chk("wrap1", rb[1], 8'h02);
        chk("wrap2", rb[2], 8'h07);
        // Software reset pattern clears the spare byte too
        wb[0] = 8'h77;
        wr(8'h03, 1);
        wb[0] = `RTC_SRST_PATTERN;
        wr(8'h00, 1);
        rd(8'h00, 4);
        chk("srst_ctrl", rb[0], 8'h00);
        chk("srst_ram", rb[3], 8'h00);
        // Mid-run reset with the bus idle returns the spare byte to zero
        wb[0] = 8'h6B;
        wr(8'h03, 1);
        rst_i = 1'b1;
        repeat (10) @(negedge mclk_i);
        rst_i = 1'b0;
        @(negedge mclk_i);
        rd(8'h03, 1);
        chk("rst_ram", rb[0], 8'h00);
        // Foreign address gets no acknowledge
        u_mst.start;
        u_mst.xfer({`RTC_DEV_ADDR ^ 7'h01, 1'b0, 1'b1}, q);
        u_mst.stop;
        chk("nack", {7'h0, q[0]}, 8'h01);
        // Every output rate, then gate low; one count of edges per 128 oscillator rises
        run = 1'b1;
        for (int c = 0; c < 9; c++) begin
            wb[0] = c[7:0] & 8'h07;
            gate = (c < 8);
            wr(8'h01, 1);
            repeat (8) @(negedge mclk_i);
            edges = 0;
            repeat (256) @(negedge mclk_i);
            exp_n = (c < 6 && c < 8) ? (128 >> c) : 0;
            chk("clk_rate", {7'h0, edges >= exp_n - 1 && edges <= exp_n + 1}, 8'h01);
        end
        // Halt clears the divider; the first tick then lands inside a read
        wb[0] = 8'h20;
        wr(8'h00, 1);
        wb[0] = 8'h59;
        wb[1] = 8'h59;
        wb[2] = 8'h23;
        wr(sec, 3);
        wb[0] = 8'h00;
        wr(8'h00, 1);
        repeat (64926) @(negedge mclk_i);
        rd(sec, 3);
        chk("frz_sec", rb[0], 8'h59);
        chk("frz_min", rb[1], 8'h59);
        chk("frz_hour", rb[2], 8'h23);
        rd(sec, 3);
        chk("sec", rb[0], 8'h00);
        chk("min", rb[1], 8'h00);
        chk("hour", rb[2], 8'h00);
        summarize;
    end
endmodule // rtc_core_test
